// File: ssbe_pkg.sv
/*
 Constants and carrier types for the continuous-output string encoder.
 Assumes the weighing side presents BCD weight, ounce and tare digits.
*/
package ssbe_pkg;
   // Frame characters
   localparam logic [7:0] STX_CHAR = 8'h02;
   localparam logic [7:0] CR_CHAR = 8'h0d;
   localparam logic [7:0] ZERO_CHAR = 8'h30;
   localparam logic [7:0] SPACE_CHAR = 8'h20;
   localparam logic [6:0] CHK_MASK = 7'h7f;
   localparam int FRAME_LEN = 17;
   localparam int NDIG = 6;
   // Frame slot indices
   localparam int SLOT_A = 1;
   localparam int SLOT_B = 2;
   localparam int SLOT_C = 3;
   localparam int SLOT_WT = 4;
   localparam int SLOT_TR = 10;
   localparam int SLOT_CR = 16;
   // Status byte A fields
   localparam int SA_DP = 0;
   localparam int SA_SP1 = 3;
   localparam int SA_SP2 = 4;
   localparam int SA_B5 = 5;
   localparam int SA_B6 = 6;
   // Status byte B fields
   localparam int SB_NET = 0;
   localparam int SB_NEG = 1;
   localparam int SB_OOR = 2;
   localparam int SB_MOT = 3;
   localparam int SB_KG = 4;
   localparam int SB_B5 = 5;
   localparam int SB_B6 = 6;
   // Status byte C fields
   localparam int SC_UNIT = 0;
   localparam int SC_PRN = 3;
   localparam int SC_B4 = 4;
   localparam int SC_B5 = 5;
   localparam int SC_B6 = 6;
   localparam logic [2:0] UNIT_OZ = 3'h3;
   localparam logic [2:0] SC_SP_ONES = 3'h7;
   // Register map
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] LAST_OFS = 12'h008;
   localparam int CTRL_SPMODE = 0;
   localparam int CTRL_CHK = 1;
   localparam int CTRL_RUN = 2;
   localparam logic [2:0] CTRL_RST = 3'h4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_OVR = 1;
   localparam int STAT_CNT = 16;

   typedef struct packed {
      logic [2:0] dp_code;
      logic [1:0] build_code;
      logic sp1_feeding;
      logic sp2_feeding;
      logic net;
      logic negative;
      logic out_of_range;
      logic motion;
      logic kg;
      logic sp1_out_tol;
      logic zero_not_cap;
      logic [2:0] unit_code;
      logic print_req;
      logic expand_x10;
      logic lb_oz;
      logic [23:0] weight_bcd;
      logic [23:0] oz_bcd;
      logic [23:0] tare_bcd;
   } ssbe_scale_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SEND = 2'h1,
      ST_SUM = 2'h3
   } ssbe_state_t;
endpackage

// File: ssbe_digit_ascii.sv
/*
 One weight or tare digit turned into its ASCII character.
 Assumes digits holds six BCD digits, most significant in the top nibble.
*/
`timescale 1ns/1ps
module ssbe_digit_ascii #(
   parameter int POS = 0
) (
   input wire logic [23:0] digits,
   output logic [7:0] ascii
);
   logic [3:0] d;
   logic blank;

   assign d = digits[POS*4 +: 4];
   // Least digit always shown, so a zero weight reads as 0
   if (POS == 0) begin : g_last
      assign blank = 1'b0;
   end else begin : g_upper
      assign blank = (digits[23:POS*4] == '0);
   end
   assign ascii = blank ? ssbe_pkg::SPACE_CHAR :
                  (ssbe_pkg::ZERO_CHAR | {4'h0, d});
endmodule

// File: ssbe_encoder.sv
/*
 Continuous-output string builder with setpoint or standard status bytes,
 APB control and status, and a character stream with valid/ready.
 Assumes conv_tick pulses once per conversion and scale is stable then.
*/
`timescale 1ns/1ps
module ssbe_encoder #(
   parameter int ADDR_W = 12,
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_tick,
   input wire ssbe_pkg::ssbe_scale_t scale,
   input wire logic tx_ready,
   output logic [7:0] tx_char,
   output logic tx_valid
);
   typedef struct packed {
      ssbe_pkg::ssbe_state_t st;
      logic [ssbe_pkg::FRAME_LEN-1:0][7:0] frame;
      logic [4:0] idx;
      logic [6:0] sum;
      logic [7:0] tx_char;
      logic tx_valid;
      logic setpoint_mode_select;
      logic trailing_sum_char;
      logic run;
      logic mode_f;
      logic chk_f;
      logic lboz_f;
      logic overrun;
      logic [CNT_W-1:0] count;
      logic [23:0] last_abc;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ssbe_regs_t;

   ssbe_regs_t s_r;
   ssbe_regs_t s_nxt;
   logic [7:0] sa;
   logic [7:0] sb;
   logic [7:0] sc;
   logic [23:0] wsel;
   logic [11:0][7:0] dig;
   logic [ssbe_pkg::FRAME_LEN-1:0][7:0] asm_frame;
   logic [11:0] ofs;
   logic take;
   logic busy;

   // Ounce digits replace the weight in pounds-ounces mode
   assign wsel = scale.lb_oz ? scale.oz_bcd : scale.weight_bcd;

   for (genvar g = 0; g < ssbe_pkg::NDIG; g++) begin : g_dig
      ssbe_digit_ascii #(.POS(g)) u_wt (
         .digits(wsel),
         .ascii(dig[g])
      );
      ssbe_digit_ascii #(.POS(g)) u_tr (
         .digits(scale.tare_bcd),
         .ascii(dig[g+ssbe_pkg::NDIG])
      );
   end

   assign ofs = 12'(paddr);
   assign busy = (s_r.st != ssbe_pkg::ST_IDLE);
   assign take = psel & penable & s_r.pready;

   always_comb begin
      // Status bytes for the next string
      sa = 8'h00;
      sb = 8'h00;
      sc = 8'h00;
      sa[ssbe_pkg::SA_DP +: 3] = scale.dp_code;
      sa[ssbe_pkg::SA_B5] = 1'b1;
      sb[ssbe_pkg::SB_NET] = scale.net;
      sb[ssbe_pkg::SB_NEG] = scale.negative;
      sb[ssbe_pkg::SB_OOR] = scale.out_of_range;
      sb[ssbe_pkg::SB_MOT] = scale.motion;
      sb[ssbe_pkg::SB_KG] = scale.kg;
      sb[ssbe_pkg::SB_B5] = 1'b1;
      sc[ssbe_pkg::SC_UNIT +: 3] = scale.lb_oz ? ssbe_pkg::UNIT_OZ :
                                   scale.unit_code;
      sc[ssbe_pkg::SC_PRN] = scale.print_req;
      sc[ssbe_pkg::SC_B5] = 1'b1;
      if (s_r.setpoint_mode_select) begin
         sa[ssbe_pkg::SA_SP1] = ~scale.sp1_feeding;
         sa[ssbe_pkg::SA_SP2] = ~scale.sp2_feeding;
         sa[ssbe_pkg::SA_B6] = 1'b1;
         sb[ssbe_pkg::SB_B6] = scale.sp1_out_tol;
         sc[ssbe_pkg::SC_B4 +: 3] = ssbe_pkg::SC_SP_ONES;
      end else begin
         sa[ssbe_pkg::SA_SP1 +: 2] = scale.build_code;
         sb[ssbe_pkg::SB_B6] = scale.zero_not_cap;
         sc[ssbe_pkg::SC_B4] = scale.expand_x10;
      end
      // Same framing in both modes, only bytes A to C differ
      asm_frame = '0;
      asm_frame[0] = ssbe_pkg::STX_CHAR;
      asm_frame[ssbe_pkg::SLOT_A] = sa;
      asm_frame[ssbe_pkg::SLOT_B] = sb;
      asm_frame[ssbe_pkg::SLOT_C] = sc;
      for (int k = 0; k < ssbe_pkg::NDIG; k++) begin
         asm_frame[ssbe_pkg::SLOT_WT+k] = dig[ssbe_pkg::NDIG-1-k];
         asm_frame[ssbe_pkg::SLOT_TR+k] = dig[2*ssbe_pkg::NDIG-1-k];
      end
      asm_frame[ssbe_pkg::SLOT_CR] = ssbe_pkg::CR_CHAR;

      s_nxt = s_r;
      // Stream engine
      case (s_r.st)
         ssbe_pkg::ST_IDLE: begin
            if (conv_tick && s_r.run) begin
               s_nxt.st = ssbe_pkg::ST_SEND;
               s_nxt.frame = asm_frame;
               s_nxt.idx = 5'h00;
               s_nxt.sum = 7'h00;
               s_nxt.mode_f = s_r.setpoint_mode_select;
               s_nxt.chk_f = s_r.trailing_sum_char;
               s_nxt.lboz_f = scale.lb_oz;
               s_nxt.last_abc = {sa, sb, sc};
            end
         end
         ssbe_pkg::ST_SEND: begin
            if (!s_r.tx_valid || tx_ready) begin
               if (s_r.idx < 5'(ssbe_pkg::FRAME_LEN)) begin
                  s_nxt.tx_char = s_r.frame[s_r.idx];
                  s_nxt.tx_valid = 1'b1;
                  s_nxt.sum = s_r.sum + s_r.frame[s_r.idx][6:0];
                  s_nxt.idx = s_r.idx + 5'h01;
               end else if (s_r.chk_f) begin
                  // Two's complement of the 7-bit sum so the total is zero
                  s_nxt.tx_char = {1'b0, (~s_r.sum + 7'h01) & ssbe_pkg::CHK_MASK};
                  s_nxt.st = ssbe_pkg::ST_SUM;
               end else begin
                  s_nxt.tx_valid = 1'b0;
                  s_nxt.st = ssbe_pkg::ST_IDLE;
                  s_nxt.count = s_r.count + CNT_W'(1);
               end
            end
         end
         ssbe_pkg::ST_SUM: begin
            if (tx_ready) begin
               s_nxt.tx_valid = 1'b0;
               s_nxt.st = ssbe_pkg::ST_IDLE;
               s_nxt.count = s_r.count + CNT_W'(1);
            end
         end
         default: begin
            s_nxt.st = ssbe_pkg::ST_IDLE;
            s_nxt.tx_valid = 1'b0;
         end
      endcase

      // APB slave, one wait state; write lands at the pready edge
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (psel && penable && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h0;
         if (ofs == ssbe_pkg::CTRL_OFS) begin
            s_nxt.prdata[ssbe_pkg::CTRL_SPMODE] = s_r.setpoint_mode_select;
            s_nxt.prdata[ssbe_pkg::CTRL_CHK] = s_r.trailing_sum_char;
            s_nxt.prdata[ssbe_pkg::CTRL_RUN] = s_r.run;
         end else if (ofs == ssbe_pkg::STAT_OFS) begin
            s_nxt.prdata[ssbe_pkg::STAT_BUSY] = busy;
            s_nxt.prdata[ssbe_pkg::STAT_OVR] = s_r.overrun;
            s_nxt.prdata[ssbe_pkg::STAT_CNT +: CNT_W] = s_r.count;
         end else if (ofs == ssbe_pkg::LAST_OFS) begin
            s_nxt.prdata[23:0] = s_r.last_abc;
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end
      if (take && pwrite) begin
         if (ofs == ssbe_pkg::CTRL_OFS) begin
            s_nxt.setpoint_mode_select = pwdata[ssbe_pkg::CTRL_SPMODE];
            s_nxt.trailing_sum_char = pwdata[ssbe_pkg::CTRL_CHK];
            s_nxt.run = pwdata[ssbe_pkg::CTRL_RUN];
         end else if (ofs == ssbe_pkg::STAT_OFS) begin
            if (pwdata[ssbe_pkg::STAT_OVR]) begin
               s_nxt.overrun = 1'b0;
            end
         end
      end
      // A tick while a string is still leaving is lost; set beats clear
      if (conv_tick && s_r.run && busy) begin
         s_nxt.overrun = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.st <= ssbe_pkg::ST_IDLE;
         s_r.run <= ssbe_pkg::CTRL_RST[ssbe_pkg::CTRL_RUN];
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign tx_char = s_r.tx_char;
   assign tx_valid = s_r.tx_valid;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_cr_taken;
      ce && s_r.st == ssbe_pkg::ST_SEND && tx_valid && tx_ready &&
         s_r.idx == 5'(ssbe_pkg::FRAME_LEN);
   endsequence

   sequence s_start;
      ce && s_r.st == ssbe_pkg::ST_IDLE && conv_tick && s_r.run;
   endsequence

   stx_first_a: assert property ($rose(tx_valid) |->
      tx_char == ssbe_pkg::STX_CHAR)
      else $error("string does not open with start of text");
   mode_gate_a: assert property (tx_valid && s_r.idx == 5'h02 |->
      tx_char[ssbe_pkg::SA_B6] == s_r.mode_f)
      else $error("byte A bit 6 does not follow the mode");
   sa_fixed_a: assert property (tx_valid && s_r.idx == 5'h02 |->
      tx_char[ssbe_pkg::SA_B5])
      else $error("byte A bit 5 not set");
   sb_fixed_a: assert property (tx_valid && s_r.idx == 5'h03 |->
      tx_char[ssbe_pkg::SB_B5])
      else $error("byte B bit 5 not set");
   sc_fixed_a: assert property (tx_valid && s_r.idx == 5'h04 &&
      s_r.mode_f |-> tx_char[6:4] == ssbe_pkg::SC_SP_ONES)
      else $error("byte C bits 4 to 6 not set in setpoint mode");
   lboz_unit_a: assert property (tx_valid && s_r.idx == 5'h04 &&
      s_r.lboz_f |-> tx_char[2:0] == ssbe_pkg::UNIT_OZ)
      else $error("pounds-ounces string not marked as ounces");
   digit_char_a: assert property (tx_valid && s_r.idx > 5'h04 &&
      s_r.idx < 5'h11 |-> tx_char == ssbe_pkg::SPACE_CHAR ||
      (tx_char >= ssbe_pkg::ZERO_CHAR && tx_char <= 8'h39))
      else $error("weight or tare slot is not a digit or space");
   cr_last_a: assert property (tx_valid && s_r.st == ssbe_pkg::ST_SEND &&
      s_r.idx == 5'(ssbe_pkg::FRAME_LEN) |-> tx_char == ssbe_pkg::CR_CHAR)
      else $error("last frame slot is not carriage return");
   chk_gate_a: assert property (s_cr_taken |=>
      (tx_valid == s_r.chk_f) && (s_r.st == ssbe_pkg::ST_SUM) == s_r.chk_f)
      else $error("checksum sent against the enable");
   tick_start_a: assert property (s_start ##1 ce[*2] |->
      tx_valid && tx_char == ssbe_pkg::STX_CHAR)
      else $error("conversion tick did not start a string");
   hold_char_a: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_char))
      else $error("character changed while stalled");
endmodule

// File: ssbe_sink.sv
/*
 Receiver at the far end of the character stream, taking one char a handshake.
 Assumes the encoder holds tx_char with tx_valid until it is accepted.
*/
`timescale 1ns/1ps
module ssbe_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic [7:0] tx_char,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] got [0:19];
   int len;
   int frames;
   logic in_str;
   logic tog;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len <= 0;
         frames <= 0;
         in_str <= 1'b0;
         tog <= 1'b0;
         tx_ready <= 1'b0;
      end else begin
         tog <= ~tog;
         // Slow receiver stalls every other cycle
         tx_ready <= slow ? tog : 1'b1;
         if (tx_valid && tx_ready) begin
            got[in_str ? len : 0] <= tx_char;
            len <= in_str ? len + 1 : 1;
            in_str <= 1'b1;
         end else if (!tx_valid) begin
            if (in_str) frames <= frames + 1;
            in_str <= 1'b0;
         end
      end
   end
endmodule

// File: ssbe_encoder_test.sv
/*
 Self-checking bench for the string encoder: APB master, tick source, sink.
 Assumes the hand-over timing: one wait state per APB transfer.
*/
`timescale 1ns/1ps
module ssbe_encoder_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, tx_ready, tx_valid;
   logic conv_tick = 1'b0, slow = 1'b0;
   logic ce = 1'b1;
   logic [7:0] tx_char;
   logic [7:0] am = 8'hff;
   logic [7:0] ef [0:17];
   ssbe_pkg::ssbe_scale_t scale = '0;
   int failures = 0, n_tests = 0;

   ssbe_encoder ssbe_encoder_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_tick(conv_tick), .scale(scale), .tx_ready(tx_ready),
      .tx_char(tx_char), .tx_valid(tx_valid));
   ssbe_sink sink_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
      .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready));

   initial forever #4 pclk = ~pclk;

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [7:0] dg(input logic [23:0] v, input int i);
      // Last digit is never blanked, so a zero weight still shows one digit
      if (i < 5 && (v >> (20 - 4 * i)) == 24'h0) return ssbe_pkg::SPACE_CHAR;
      return {4'h3, v[20-4*i +: 4]};
   endfunction

   function automatic logic [7:0] mk(input int i);
      return (i == 1) ? am : 8'hff;
   endfunction

   task automatic expect_str(input ssbe_pkg::ssbe_scale_t s, input logic sp);
      logic [2:0] u;
      logic [23:0] w;
      logic [6:0] cs;
      u = s.lb_oz ? ssbe_pkg::UNIT_OZ : s.unit_code;
      w = s.lb_oz ? s.oz_bcd : s.weight_bcd;
      // Standard byte A upper bits are not pinned down, so mask them
      am = sp ? 8'hff : 8'h27;
      ef[0] = ssbe_pkg::STX_CHAR;
      ef[1] = {3'b011, ~s.sp2_feeding, ~s.sp1_feeding, s.dp_code};
      ef[2] = {1'b0, sp ? s.sp1_out_tol : s.zero_not_cap, 1'b1, s.kg,
               s.motion, s.out_of_range, s.negative, s.net};
      ef[3] = sp ? {4'b0111, s.print_req, u}
                 : {3'b001, s.expand_x10, s.print_req, u};
      for (int i = 0; i < 6; i++) begin
         ef[4+i] = dg(w, i);
         ef[10+i] = dg(s.tare_bcd, i);
      end
      ef[16] = ssbe_pkg::CR_CHAR;
      cs = 7'h0;
      for (int i = 0; i < 17; i++) cs = cs + ef[i][6:0];
      ef[17] = {1'b0, -cs};
   endtask

   task automatic tick();
      @(posedge pclk);
      conv_tick <= 1'b1;
      @(posedge pclk);
      conv_tick <= 1'b0;
   endtask

   task automatic frame(input int n, input logic dbl);
      int f0;
      int k;
      f0 = sink_inst.frames;
      tick();
      if (dbl) begin
         repeat (2) @(posedge pclk);
         tick();
      end
      k = 0;
      while (sink_inst.frames == f0 && k < 300) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 300) failures++;
      chk(sink_inst.len, n);
      for (int i = 0; i < n; i++)
         chk(sink_inst.got[i] & mk(i), ef[i] & mk(i));
   endtask

   task automatic t_regs();
      apb(1'b0, ssbe_pkg::CTRL_OFS, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      chk(err, 1'b1);
   endtask

   task automatic t_sp_units();
      ssbe_pkg::ssbe_scale_t s;
      apb(1'b1, ssbe_pkg::CTRL_OFS, 32'h5);
      for (int u = 0; u < 8; u++) begin
         s = '0;
         s.unit_code = u[2:0];
         s.dp_code = 3'(1 + u % 5);
         {s.sp1_feeding, s.sp2_feeding, s.out_of_range} = u[2:0];
         {s.net, s.negative, s.motion, s.kg} = {u[0], u[1], ~u[0], u[1]};
         {s.sp1_out_tol, s.print_req} = {u[2], ~u[1]};
         {s.zero_not_cap, s.expand_x10, s.build_code} = 4'hf;
         s.weight_bcd = 24'h000907 << (4 * u);
         s.tare_bcd = 24'h012340 >> (4 * u);
         scale <= s;
         slow <= u[0];
         expect_str(s, 1'b1);
         frame(17, 1'b0);
         chk(sink_inst.got[1], ef[1]);
         chk(sink_inst.got[2], ef[2]);
         chk(sink_inst.got[3], ef[3]);
      end
      apb(1'b0, ssbe_pkg::LAST_OFS, 32'h0);
      chk(rd, {8'h0, ef[1], ef[2], ef[3]});
   endtask

   task automatic t_std_lboz();
      ssbe_pkg::ssbe_scale_t s;
      s = '0;
      {s.zero_not_cap, s.expand_x10, s.dp_code, s.unit_code} = 8'he2;
      s.weight_bcd = 24'h123456;
      apb(1'b1, ssbe_pkg::CTRL_OFS, 32'h4);
      scale <= s;
      expect_str(s, 1'b0);
      frame(17, 1'b0);
      chk(sink_inst.got[2], ef[2]);
      chk(sink_inst.got[3], ef[3]);
      s = '0;
      {s.lb_oz, s.unit_code, s.dp_code} = 7'h4a;
      {s.weight_bcd, s.oz_bcd, s.tare_bcd} = {24'h2, 24'h32, 24'h100000};
      apb(1'b1, ssbe_pkg::CTRL_OFS, 32'h7);
      scale <= s;
      expect_str(s, 1'b1);
      frame(18, 1'b0);
      chk(sink_inst.got[3], ef[3]);
   endtask

   task automatic t_ovr();
      logic [31:0] c0;
      int f0;
      apb(1'b1, ssbe_pkg::CTRL_OFS, 32'h5);
      apb(1'b0, ssbe_pkg::STAT_OFS, 32'h0);
      c0 = rd;
      f0 = sink_inst.frames;
      expect_str(scale, 1'b1);
      frame(17, 1'b1);
      chk(sink_inst.frames, f0 + 1);
      apb(1'b0, ssbe_pkg::STAT_OFS, 32'h0);
      chk(rd, {c0[31:16] + 16'h1, 16'h2});
      apb(1'b1, ssbe_pkg::STAT_OFS, 32'h2);
      apb(1'b1, ssbe_pkg::CTRL_OFS, 32'h1);
      tick();
      // Absence check: no string may start within this span
      repeat (40) @(posedge pclk);
      chk(sink_inst.frames, f0 + 1);
      apb(1'b0, ssbe_pkg::STAT_OFS, 32'h0);
      chk(rd, {c0[31:16] + 16'h1, 16'h0});
   endtask

   // Tick with the enable low must be lost; after it the stream still works
   task automatic t_freeze();
      int f0;
      apb(1'b1, ssbe_pkg::CTRL_OFS, 32'h5);
      f0 = sink_inst.frames;
      @(posedge pclk);
      ce <= 1'b0;
      tick();
      repeat (40) @(posedge pclk);
      chk(tx_valid, 1'b0);
      ce <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(sink_inst.frames, f0);
      expect_str(scale, 1'b1);
      frame(17, 1'b0);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      test_done();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_sp_units();
      t_std_lboz();
      t_ovr();
      t_freeze();
      test_done();
   end
endmodule
